// ===== dsl_top.sv
// sixteen channel converter load control: registers, load strobe, span, link glue
`timescale 1ns/1ps
`default_nettype none
`include "dsl_params.svh"

// Behaviour
// - frame starts at sync low; the next 24 falling clock edges carry the word
// - serial input shifts into a 24-bit register on each falling clock edge while sync is low
// - load strobe low copies every input register with new data to its output register
// - load strobe works as pulse or level, including held low permanently
// - serial output launched on rising edges, sampled by the receiver on falling edges
// - reset acts asynchronously on its falling edge
// - load strobe pulses are ignored while reset is low
// - reset loads zero scale into input and output registers
// - span select sets the span of all sixteen outputs together
module dsl_top (
    // system clock and reset
    input wire logic CLK_SYS,
    input wire logic RST_N,
    // serial link
    input wire logic SCLK_LINK,
    input wire logic SYNC_N,
    input wire logic SDI,
    output logic SDO,
    output logic SDO_OE,
    // control pins
    input wire logic LOAD_STROBE_N,
    input wire logic SPAN_SEL,
    // converter codes and span
    output dsl_pkg::dsl_code_t [`DSL_CHANNELS-1:0] DAC_CODE,
    output logic SPAN_DOUBLE,
    // buffer status
    output logic WORD_READY,
    output logic WORD_DROP
);

    localparam int CH = `DSL_CHANNELS;

    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed {
        logic [`DSL_SYNC_STAGES-1:0] word_sync;
        logic word_seen;
        logic [`DSL_SYNC_STAGES-1:0] load_sync;
        logic load_seen;
        logic [`DSL_SYNC_STAGES-1:0] level_sync;
        logic [`DSL_SYNC_STAGES-1:0] span_sync;
        logic span_double;
        logic push;
        dsl_pkg::dsl_word_t push_word;
        logic drop;
        dsl_pkg::dsl_code_t [CH-1:0] input_code;
        dsl_pkg::dsl_code_t [CH-1:0] dac_code;
        dsl_pkg::dsl_mask_t pending;
    } dsl_sys_state_t;

    dsl_sys_state_t st_reg;
    dsl_sys_state_t st_next;

    dsl_pkg::dsl_word_t link_word;
    logic link_toggle;
    logic load_toggle_reg;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_out_ready;
    dsl_pkg::dsl_word_t fifo_out_data;
    logic word_event;
    logic load_event;
    logic strobe_low;
    logic take;
    dsl_pkg::dsl_mask_t copy_mask;
    dsl_pkg::dsl_mask_t wr_input_mask;
    dsl_pkg::dsl_mask_t wr_update_mask;
    dsl_pkg::dsl_mask_t upd_mask;

    // ****************************************************************
    // decode helpers
    // ****************************************************************
    function automatic dsl_pkg::dsl_mask_t chan_onehot(input logic [`DSL_CHAN_BITS-1:0] chan);
        dsl_pkg::dsl_mask_t m;
        m = '0;
        m[chan] = 1'b1;
        return m;
    endfunction

    function automatic dsl_pkg::dsl_mask_t cmd_mask(input logic en, input dsl_pkg::dsl_word_t w,
                                                    input logic [`DSL_CMD_BITS-1:0] cmd);
        dsl_pkg::dsl_mask_t m;
        m = '0;
        if (en && (w.cmd == cmd)) begin
            m = chan_onehot(w.chan);
        end
        return m;
    endfunction

    // ****************************************************************
    // serial link and word buffer
    // ****************************************************************
    dsl_link u_link (
        .sclk(SCLK_LINK),
        .rst_n(RST_N),
        .sync_n(SYNC_N),
        .sdi(SDI),
        .sdo(SDO),
        .sdo_oe(SDO_OE),
        .word(link_word),
        .word_toggle(link_toggle)
    );

    dsl_fifo #(
        .WIDTH(`DSL_WORD_BITS),
        .DEPTH(`DSL_FIFO_DEPTH)
    ) u_fifo (
        .clk(CLK_SYS),
        .rst_n(RST_N),
        .in_valid(st_reg.push),
        .in_ready(fifo_in_ready),
        .in_data(st_reg.push_word),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data)
    );

    // ****************************************************************
    // load strobe edge catcher
    // ****************************************************************
    // a pulse far shorter than the system clock is caught here, held clear during reset
    always_ff @(negedge LOAD_STROBE_N or negedge RST_N) begin
        if (!RST_N) begin
            load_toggle_reg <= 1'b0;
        end else begin
            load_toggle_reg <= ~load_toggle_reg;
        end
    end

    // ****************************************************************
    // system side behaviour
    // ****************************************************************
    assign word_event = st_reg.word_sync[1] ^ st_reg.word_seen;
    assign load_event = st_reg.load_sync[1] ^ st_reg.load_seen;
    assign strobe_low = ~st_reg.level_sync[1];
    // executor stalls for the cycle of a strobe falling-edge copy, not for level copies
    assign fifo_out_ready = ~load_event;
    assign take = fifo_out_valid & fifo_out_ready;

    always_comb begin
        st_next = st_reg;
        st_next.word_sync = {st_reg.word_sync[0], link_toggle};
        st_next.word_seen = st_reg.word_sync[1];
        st_next.load_sync = {st_reg.load_sync[0], load_toggle_reg};
        st_next.load_seen = st_reg.load_sync[1];
        st_next.level_sync = {st_reg.level_sync[0], LOAD_STROBE_N};
        st_next.span_sync = {st_reg.span_sync[0], SPAN_SEL};
        st_next.span_double = st_reg.span_sync[1];

        // word is stable in the link register until the next word completes
        st_next.push = word_event;
        if (word_event) begin
            st_next.push_word = link_word;
        end
        if (st_reg.push && !fifo_in_ready) begin
            st_next.drop = 1'b1;
        end

        wr_input_mask = cmd_mask(take, fifo_out_data, `DSL_CMD_WRITE_INPUT);
        wr_update_mask = cmd_mask(take, fifo_out_data, `DSL_CMD_WRITE_UPDATE);
        upd_mask = cmd_mask(take, fifo_out_data, `DSL_CMD_UPDATE_CHAN);
        copy_mask = upd_mask & st_reg.pending;
        if (load_event || strobe_low || (take && (fifo_out_data.cmd == `DSL_CMD_LOAD_ALL))) begin
            copy_mask = st_reg.pending;
        end

        for (int i = 0; i < CH; i++) begin
            if (copy_mask[i]) begin
                st_next.dac_code[i] = st_reg.input_code[i];
            end
            if (wr_input_mask[i] || wr_update_mask[i]) begin
                st_next.input_code[i] = fifo_out_data.code;
            end
            if (wr_update_mask[i]) begin
                st_next.dac_code[i] = fifo_out_data.code;
            end
        end
        // a new write in the copy cycle stays pending
        st_next.pending = (st_reg.pending & ~copy_mask & ~wr_update_mask) | wr_input_mask;
    end

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            st_reg <= '0;
            st_reg.input_code <= {CH{`DSL_ZERO_CODE}};
            st_reg.dac_code <= {CH{`DSL_ZERO_CODE}};
            st_reg.level_sync <= '1;
        end else begin
            st_reg <= st_next;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign DAC_CODE = st_reg.dac_code;
    assign SPAN_DOUBLE = st_reg.span_double;
    assign WORD_READY = fifo_in_ready;
    assign WORD_DROP = st_reg.drop;

endmodule

`default_nettype wire

// ===== dsl_params.svh
// constants of the serial load control block
`ifndef DSL_PARAMS_SVH
`define DSL_PARAMS_SVH

// ****************************************************************
// frame and word layout
// ****************************************************************
`define DSL_WORD_BITS 24
`define DSL_CNT_BITS 5
`define DSL_CODE_BITS 16
`define DSL_CHANNELS 16
`define DSL_CHAN_BITS 4
`define DSL_CMD_BITS 4
`define DSL_ZERO_CODE 16'h0000

// ****************************************************************
// command codes of the word's top nibble
// ****************************************************************
`define DSL_CMD_NOP 4'h0
`define DSL_CMD_WRITE_INPUT 4'h1
`define DSL_CMD_UPDATE_CHAN 4'h2
`define DSL_CMD_WRITE_UPDATE 4'h3
`define DSL_CMD_LOAD_ALL 4'h4

// ****************************************************************
// buffering and timing
// ****************************************************************
`define DSL_FIFO_DEPTH 8
`define DSL_SYNC_STAGES 2
`define DSL_SYS_PERIOD_NS 100
`define DSL_SCLK_MAX_MHZ 50
`define DSL_SCLK_MIN_PERIOD_NS (1000 / `DSL_SCLK_MAX_MHZ)

`endif

// ===== dsl_pkg.sv
// types shared by the serial load control block
`include "dsl_params.svh"

package dsl_pkg;

    // ****************************************************************
    // carriers
    // ****************************************************************
    typedef logic [`DSL_CODE_BITS-1:0] dsl_code_t;

    typedef struct packed {
        logic [`DSL_CMD_BITS-1:0] cmd;
        logic [`DSL_CHAN_BITS-1:0] chan;
        dsl_code_t code;
    } dsl_word_t;

    typedef logic [`DSL_CHANNELS-1:0] dsl_mask_t;

endpackage

// ===== dsl_fifo.sv
// word buffer between the link capture and the command executor
`timescale 1ns/1ps
`default_nettype none

module dsl_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);

    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW:0] wp;
        logic [AW:0] rp;
    } dsl_fifo_state_t;

    dsl_fifo_state_t st_reg;
    dsl_fifo_state_t st_next;
    logic [AW:0] fill;

    // pointers carry one wrap bit; depth must be a power of two
    assign fill = st_reg.wp - st_reg.rp;
    assign in_ready = (fill != (AW + 1)'(DEPTH));
    assign out_valid = (fill != '0);
    assign out_data = st_reg.mem[st_reg.rp[AW-1:0]];

    always_comb begin
        st_next = st_reg;
        if (in_valid && in_ready) begin
            st_next.mem[st_reg.wp[AW-1:0]] = in_data;
            st_next.wp = st_reg.wp + 1'b1;
        end
        if (out_valid && out_ready) begin
            st_next.rp = st_reg.rp + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

endmodule

`default_nettype wire

// ===== dsl_link.sv
// serial clock side: shift register, word capture and chain output
`timescale 1ns/1ps
`default_nettype none
`include "dsl_params.svh"

module dsl_link (
    // serial clock and reset
    input wire logic sclk,
    input wire logic rst_n,
    // serial pins
    input wire logic sync_n,
    input wire logic sdi,
    output logic sdo,
    output logic sdo_oe,
    // captured word, toggled once per word
    output dsl_pkg::dsl_word_t word,
    output logic word_toggle
);

    typedef struct packed {
        logic [`DSL_WORD_BITS-1:0] shift;
        logic [`DSL_WORD_BITS-1:0] word;
        logic toggle;
    } dsl_link_state_t;

    dsl_link_state_t st_reg;
    dsl_link_state_t st_next;
    logic [`DSL_CNT_BITS-1:0] cnt_reg;
    logic [`DSL_CNT_BITS-1:0] cnt_next;
    logic frame_rst_n;
    logic sdo_reg;

    // bit count lives only inside a frame; raising sync clears it
    assign frame_rst_n = rst_n & ~sync_n;
    assign word = dsl_pkg::dsl_word_t'(st_reg.word);
    assign word_toggle = st_reg.toggle;
    assign sdo = sdo_reg;
    assign sdo_oe = ~sync_n;

    always_comb begin
        st_next = st_reg;
        cnt_next = cnt_reg;
        if (!sync_n) begin
            st_next.shift = {st_reg.shift[`DSL_WORD_BITS-2:0], sdi};
            if (cnt_reg != `DSL_CNT_BITS'(`DSL_WORD_BITS)) begin
                cnt_next = cnt_reg + 1'b1;
            end
            if (cnt_reg == `DSL_CNT_BITS'(`DSL_WORD_BITS - 1)) begin
                st_next.word = {st_reg.shift[`DSL_WORD_BITS-2:0], sdi};
                st_next.toggle = ~st_reg.toggle;
            end
        end
    end

    // capture on falling serial clock edges
    always_ff @(negedge sclk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    always_ff @(negedge sclk or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end

    // chain output launched on rising edges
    always_ff @(posedge sclk or negedge rst_n) begin
        if (!rst_n) begin
            sdo_reg <= 1'b0;
        end else begin
            sdo_reg <= st_reg.shift[`DSL_WORD_BITS-1];
        end
    end

endmodule

`default_nettype wire

// ===== dsl_handover_end.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ===== dsl_top_assertions.sv
// assertion checker for the serial load control top
`timescale 1ns/1ps
`default_nettype none
`include "dsl_params.svh"
module dsl_top_assertions (
    // clock and reset
    input wire logic CLK_SYS,
    input wire logic RST_N,
    // pins
    input wire logic SYNC_N,
    input wire logic SDO,
    input wire logic SDO_OE,
    input wire logic LOAD_STROBE_N,
    input wire logic SPAN_SEL,
    // outputs
    input wire dsl_pkg::dsl_code_t [`DSL_CHANNELS-1:0] DAC_CODE,
    input wire logic SPAN_DOUBLE,
    input wire logic WORD_READY,
    input wire logic WORD_DROP
);
    a_span_high: assert property (
        @(posedge CLK_SYS) disable iff (!RST_N) SPAN_SEL [*4] |-> SPAN_DOUBLE) else $error("span not doubled");
    a_span_low: assert property (
        @(posedge CLK_SYS) disable iff (!RST_N) !SPAN_SEL [*4] |-> !SPAN_DOUBLE) else $error("span not single");
    a_span_cause: assert property (
        @(posedge CLK_SYS) disable iff (!RST_N) $changed(SPAN_DOUBLE) |-> SPAN_DOUBLE == $past(SPAN_SEL, 3))
        else $error("span moved without cause");
    a_reset_zero: assert property (
        @(posedge CLK_SYS) disable iff (!RST_N) $rose(RST_N) |-> DAC_CODE == '0 && !SDO && !SPAN_DOUBLE)
        else $error("reset state wrong");
    a_oe_sync: assert property (
        @(posedge CLK_SYS) disable iff (!RST_N) SDO_OE == !SYNC_N) else $error("output enable wrong");
    a_drop_sticky: assert property (
        @(posedge CLK_SYS) disable iff (!RST_N) WORD_DROP |=> WORD_DROP) else $error("drop flag lost");
    a_codes_quiet: assert property (
        @(posedge CLK_SYS) disable iff (!RST_N) (SYNC_N && LOAD_STROBE_N) [*8] |-> $stable(DAC_CODE))
        else $error("codes moved while idle");
    a_idle_ready: assert property (
        @(posedge CLK_SYS) disable iff (!RST_N) SYNC_N [*8] |-> WORD_READY) else $error("buffer not ready idle");
endmodule
bind dsl_top dsl_top_assertions chk (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .SYNC_N(SYNC_N), .SDO(SDO),
    .SDO_OE(SDO_OE), .LOAD_STROBE_N(LOAD_STROBE_N), .SPAN_SEL(SPAN_SEL), .DAC_CODE(DAC_CODE),
    .SPAN_DOUBLE(SPAN_DOUBLE), .WORD_READY(WORD_READY), .WORD_DROP(WORD_DROP));
`default_nettype wire

// ===== dsl_host_model.sv
// host serial controller model driving frames into the link
`timescale 1ns/1ps
`default_nettype none
`include "dsl_params.svh"
module dsl_host_model (
    // serial pins
    output logic sclk,
    output logic sync_n,
    output logic sdi,
    input wire logic sdo
);
    logic [23:0] rx;
    // half of the fastest serial clock period the device accepts
    localparam int half_period_ns = `DSL_SCLK_MIN_PERIOD_NS / 2;
    initial begin
        sclk = 1'b1;
        sync_n = 1'b1;
        sdi = 1'b0;
        rx = '0;
    end
    // clock stands high outside frames; released data shows inverse
    task automatic send_word(input dsl_pkg::dsl_word_t w);
        #1 sync_n = 1'b0;
        for (int i = 23; i >= 0; i--) begin
            sdi = w[i];
            #half_period_ns sclk = 1'b0;
            rx = {rx[22:0], sdo};
            #half_period_ns sclk = 1'b1;
        end
        #half_period_ns sync_n = 1'b1;
        sdi = ~sdi;
    endtask
endmodule
`default_nettype wire

// ===== tb.sv
// self-checking bench for the serial load control top
`timescale 1ns/1ps
`default_nettype none
`include "dsl_params.svh"
module tb;
    logic clk_sys, rst_n, load_strobe_n, span_sel, sclk, sync_n, sdi, sdo, sdo_oe;
    logic span_double, word_ready, word_drop;
    dsl_pkg::dsl_code_t [`DSL_CHANNELS-1:0] dac_code, exp_code;
    int num_errors = 0;
    int checked = 0;
    int cycles = 0;
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    dsl_host_model host (.sclk(sclk), .sync_n(sync_n), .sdi(sdi), .sdo(sdo));
    dsl_top DUT (.CLK_SYS(clk_sys), .RST_N(rst_n), .SCLK_LINK(sclk), .SYNC_N(sync_n), .SDI(sdi), .SDO(sdo),
        .SDO_OE(sdo_oe), .LOAD_STROBE_N(load_strobe_n), .SPAN_SEL(span_sel), .DAC_CODE(dac_code),
        .SPAN_DOUBLE(span_double), .WORD_READY(word_ready), .WORD_DROP(word_drop));
    task automatic final_report();
        $display("checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk_codes(input string what);
        checked++;
        if (dac_code !== exp_code) begin
            num_errors++;
            $display("[ERR] %0t codes %s", $time, what);
        end
    endtask
    task automatic chk_val(input logic [23:0] got, input logic [23:0] want, input string what);
        checked++;
        if (got !== want) begin
            num_errors++;
            $display("[ERR] %0t %s got %h", $time, what, got);
        end
    endtask
    task automatic xfer(input logic [3:0] cmd, input logic [3:0] ch, input dsl_pkg::dsl_code_t code);
        host.send_word({cmd, ch, code});
        repeat (10) @(posedge clk_sys);
    endtask
    task automatic pulse_load();
        load_strobe_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        load_strobe_n <= 1'b1;
        repeat (6) @(posedge clk_sys);
    endtask
    task automatic t_write_update();
        chk_codes("after reset");
        xfer(4'h3, 4'h0, 16'hffff);
        xfer(4'h3, 4'hf, 16'h0001);
        exp_code[0] = 16'hffff;
        exp_code[15] = 16'h0001;
        chk_codes("write update");
        $display("t_write_update done");
    endtask
    task automatic t_pulse_load();
        xfer(4'h1, 4'h5, 16'ha5a5);
        xfer(4'h1, 4'h6, 16'h5a5a);
        chk_codes("input only");
        pulse_load();
        exp_code[5] = 16'ha5a5;
        exp_code[6] = 16'h5a5a;
        chk_codes("pulse load");
        pulse_load();
        chk_codes("second pulse");
        $display("t_pulse_load done");
    endtask
    task automatic t_cmds();
        xfer(4'h1, 4'h9, 16'h1234);
        xfer(4'h0, 4'h9, 16'hffff);
        xfer(4'hf, 4'h9, 16'hffff);
        chk_codes("nop and unknown");
        xfer(4'h2, 4'h9, 16'h0000);
        exp_code[9] = 16'h1234;
        chk_codes("channel update");
        xfer(4'h1, 4'ha, 16'h4321);
        xfer(4'h4, 4'h0, 16'h0000);
        exp_code[10] = 16'h4321;
        chk_codes("load all");
        $display("t_cmds done");
    endtask
    task automatic t_level_load();
        load_strobe_n <= 1'b0;
        repeat (4) @(posedge clk_sys);
        xfer(4'h1, 4'h7, 16'h0f0f);
        exp_code[7] = 16'h0f0f;
        chk_codes("held low");
        load_strobe_n <= 1'b1;
        repeat (2) @(posedge clk_sys);
        $display("t_level_load done");
    endtask
    task automatic t_chain();
        host.send_word(24'h0c9a61);
        repeat (10) @(posedge clk_sys);
        host.send_word(24'h03beef);
        chk_val(host.rx, 24'h0c9a61, "chain out");
        repeat (10) @(posedge clk_sys);
        chk_codes("nop frames");
        chk_val({21'h0, sdo_oe, word_ready, word_drop}, 24'h000002, "pin status");
        $display("t_chain done");
    endtask
    task automatic t_span();
        span_sel <= 1'b1;
        repeat (4) @(posedge clk_sys);
        chk_val({23'h0, span_double}, 24'h1, "span high");
        span_sel <= 1'b0;
        repeat (4) @(posedge clk_sys);
        chk_val({23'h0, span_double}, 24'h0, "span low");
        $display("t_span done");
    endtask
    task automatic t_reset_mid();
        xfer(4'h1, 4'h2, 16'h7777);
        rst_n <= 1'b0;
        exp_code = '0;
        #10 chk_codes("async reset");
        @(posedge clk_sys);
        pulse_load();
        chk_codes("load in reset");
        rst_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        pulse_load();
        chk_codes("input zeroed");
        $display("t_reset_mid done");
    endtask
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            $display("[ERR] %0t timeout", $time);
            final_report();
        end
    end
    initial begin
        rst_n = 1'b0;
        load_strobe_n = 1'b1;
        span_sel = 1'b0;
        exp_code = '0;
        repeat (5) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk_sys);
        t_write_update();
        t_pulse_load();
        t_cmds();
        t_level_load();
        t_chain();
        t_span();
        t_reset_mid();
        final_report();
    end
endmodule
`default_nettype wire
